// ==== ioxp_top.sv ====
/*
 * Forty-pin I/O expander behind a serial two-wire target interface.
 * The serial clock clocks the protocol engine and the writable registers;
 * the reference clock clocks input sampling and the interrupt.
 * Assumes scl is a clean clock and the address select pins are static.
 */
// How it works
// - Forty pins in five byte-wide banks of eight.
// - Each pin is input or driven output by its direction bit.
// - Written output byte reaches the pins at its acknowledge.
// - Suppress bit set keeps that pin from raising the interrupt.
// - Invert bit set flips the level returned on input reads.
// - Interrupt asserts when any unsuppressed input pin changes level.
// - Interrupt is open-drain active low, watching input pins only.
// - Output enable high puts every output pin in high impedance.
// - Reset makes all forty pins inputs.
// - Reset returns all state to the power-up defaults.
// - Three address select pins form the low address bits.
// - Works at standard and fast bus rates; controller stays at or below fast.
// - No glitch filter on the serial lines; a data transient while the clock is high is taken as start or stop.
// - Last address bit: one means read, zero means write.
// - First byte after write address is the command; low six bits point.
// - With auto-increment set, bank bits advance after each data byte.
// - Command byte resets to auto-increment on, pointer zero.
`timescale 1ns/1ps
module ioxp_top (
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Address select straps
    input wire logic addr_sel0,
    input wire logic addr_sel1,
    input wire logic addr_sel2,
    // Output enable, active low
    input wire logic oe_n,
    // Pin banks
    input wire logic [7:0] pins_bank0_in,
    output logic [7:0] pins_bank0_out,
    output logic [7:0] pins_bank0_oe,
    input wire logic [7:0] pins_bank1_in,
    output logic [7:0] pins_bank1_out,
    output logic [7:0] pins_bank1_oe,
    input wire logic [7:0] pins_bank2_in,
    output logic [7:0] pins_bank2_out,
    output logic [7:0] pins_bank2_oe,
    input wire logic [7:0] pins_bank3_in,
    output logic [7:0] pins_bank3_out,
    output logic [7:0] pins_bank3_oe,
    input wire logic [7:0] pins_bank4_in,
    output logic [7:0] pins_bank4_out,
    output logic [7:0] pins_bank4_oe,
    // Interrupt, open drain
    output logic irq_n_out,
    output logic irq_n_oe
);
    typedef enum logic [3:0] {
        LS_IDLE, LS_ADDR, LS_AACK, LS_CMD, LS_CACK, LS_WDAT, LS_WACK, LS_RDAT, LS_RACK
    } ioxp_lstate_t;

    ioxp_link_if lnk ();
    ioxp_edge u_edge (
        .scl(scl),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .rst(rst),
        .lnk(lnk)
    );

    // Serial clock domain
    ioxp_lstate_t state_ff;
    logic [2:0] cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] cmd_ff;
    logic [7:0] rbyte_ff;
    logic ack_ok_ff;
    logic start_seen_ff;
    logic stop_seen_ff;
    logic [39:0] level_out_ff;
    logic [39:0] invert_ff;
    logic [39:0] direction_ff;
    logic [39:0] suppress_ff;
    logic [39:0] in_lnk_ff;
    logic snap_ack_ff;
    logic cfg_tog_ff;
    logic rd_tog_ff;
    logic [2:0] rd_bank_ff;
    logic [3:0] lnk_s;
    logic [2:0] addr_sel_s;
    logic snap_req_s;
    logic start_hit;
    logic stop_hit;
    logic last_bit;
    logic [7:0] byte_in;
    logic addr_match;
    logic [2:0] grp;
    logic [2:0] bank;
    logic bank_ok;
    logic wr_ok;
    logic wr_now;
    logic adv;
    logic load_rd;
    logic [7:0] rd_byte;

    logic [39:0] snap_ff;
    logic snap_req_ff;

    // Straps are static, sampled through two flops on the serial clock
    ioxp_sync #(.W(4)) u_lnk_sync (
        .clk(scl),
        .rst(rst),
        .d({snap_req_ff, addr_sel2, addr_sel1, addr_sel0}),
        .q(lnk_s)
    );
    assign addr_sel_s = lnk_s[2:0];
    assign snap_req_s = lnk_s[3];

    // Any start aborts whatever was in progress
    assign start_hit = lnk.start_ff ^ start_seen_ff;
    assign stop_hit = lnk.stop_ff ^ stop_seen_ff;
    assign last_bit = (cnt_ff == 3'h7);
    assign byte_in = {shift_ff[6:0], sda_in};
    assign addr_match = (shift_ff[7:1] == {ioxp_pkg::TGT_ADDR_HI, addr_sel_s});
    assign grp = cmd_ff[5:3];
    assign bank = cmd_ff[2:0];
    assign bank_ok = (bank <= ioxp_pkg::LAST_BANK);
    assign wr_ok = bank_ok && (grp >= ioxp_pkg::GRP_LEVEL_OUT) && (grp <= ioxp_pkg::GRP_SUPPRESS);
    assign wr_now = !start_hit && !stop_hit && (state_ff == LS_WDAT) && last_bit && wr_ok;
    assign adv = !start_hit && !stop_hit && last_bit && cmd_ff[ioxp_pkg::CMD_AUTOINC_BIT]
                 && ((state_ff == LS_WDAT) || (state_ff == LS_RDAT));
    assign load_rd = !start_hit && !stop_hit
                     && (((state_ff == LS_AACK) && addr_match && shift_ff[0])
                         || ((state_ff == LS_RACK) && !sda_in));

    always_comb begin
        rd_byte = 8'h00;
        if (bank_ok) begin
            case (grp)
                ioxp_pkg::GRP_LEVEL_IN: begin
                    rd_byte = ioxp_pkg::ioxp_get(in_lnk_ff ^ invert_ff, bank);
                end
                ioxp_pkg::GRP_LEVEL_OUT: begin
                    rd_byte = ioxp_pkg::ioxp_get(level_out_ff, bank);
                end
                ioxp_pkg::GRP_INVERT: begin
                    rd_byte = ioxp_pkg::ioxp_get(invert_ff, bank);
                end
                ioxp_pkg::GRP_DIRECTION: begin
                    rd_byte = ioxp_pkg::ioxp_get(direction_ff, bank);
                end
                ioxp_pkg::GRP_SUPPRESS: begin
                    rd_byte = ioxp_pkg::ioxp_get(suppress_ff, bank);
                end
                default: begin
                    rd_byte = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            start_seen_ff <= 1'b0;
            stop_seen_ff <= 1'b0;
        end else begin
            start_seen_ff <= lnk.start_ff;
            stop_seen_ff <= lnk.stop_ff;
        end
    end

    // Protocol engine; the first address bit arrives on the edge that sees start
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            state_ff <= LS_IDLE;
            cnt_ff <= 3'h0;
            shift_ff <= 8'h00;
        end else if (start_hit) begin
            state_ff <= LS_ADDR;
            cnt_ff <= 3'h1;
            shift_ff <= {7'h00, sda_in};
        end else if (stop_hit) begin
            state_ff <= LS_IDLE;
            cnt_ff <= 3'h0;
        end else begin
            case (state_ff)
                LS_ADDR, LS_CMD, LS_WDAT: begin
                    shift_ff <= byte_in;
                    cnt_ff <= 3'(cnt_ff + 3'h1);
                    if (last_bit) begin
                        state_ff <= (state_ff == LS_ADDR) ? LS_AACK :
                                    (state_ff == LS_CMD) ? LS_CACK : LS_WACK;
                    end
                end
                LS_AACK: begin
                    cnt_ff <= 3'h0;
                    if (!addr_match) begin
                        state_ff <= LS_IDLE;
                    end else if (shift_ff[0]) begin
                        state_ff <= LS_RDAT;
                    end else begin
                        state_ff <= LS_CMD;
                    end
                end
                LS_CACK: begin
                    cnt_ff <= 3'h0;
                    state_ff <= LS_WDAT;
                end
                LS_WACK: begin
                    cnt_ff <= 3'h0;
                    state_ff <= ack_ok_ff ? LS_WDAT : LS_IDLE;
                end
                LS_RDAT: begin
                    cnt_ff <= 3'(cnt_ff + 3'h1);
                    if (last_bit) begin
                        state_ff <= LS_RACK;
                    end
                end
                LS_RACK: begin
                    cnt_ff <= 3'h0;
                    // Controller not acknowledging ends the read
                    state_ff <= sda_in ? LS_IDLE : LS_RDAT;
                end
                default: begin
                    state_ff <= LS_IDLE;
                end
            endcase
        end
    end

    // Command byte persists across transfers
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            cmd_ff <= ioxp_pkg::CMD_RST;
        end else if (!start_hit && !stop_hit && (state_ff == LS_CMD) && last_bit) begin
            cmd_ff <= byte_in;
        end else if (adv) begin
            cmd_ff[2:0] <= ioxp_pkg::ioxp_bank_next(bank);
        end
    end

    // Input bank writes are refused with no acknowledge
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            ack_ok_ff <= 1'b0;
        end else if (!start_hit && !stop_hit && (state_ff == LS_WDAT) && last_bit) begin
            ack_ok_ff <= wr_ok;
        end
    end

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            level_out_ff <= ioxp_pkg::LEVEL_OUT_RST;
            invert_ff <= ioxp_pkg::INVERT_RST;
            direction_ff <= ioxp_pkg::DIRECTION_RST;
            suppress_ff <= ioxp_pkg::SUPPRESS_RST;
        end else if (wr_now) begin
            case (grp)
                ioxp_pkg::GRP_LEVEL_OUT: begin
                    level_out_ff <= ioxp_pkg::ioxp_put(level_out_ff, bank, byte_in);
                end
                ioxp_pkg::GRP_INVERT: begin
                    invert_ff <= ioxp_pkg::ioxp_put(invert_ff, bank, byte_in);
                end
                ioxp_pkg::GRP_DIRECTION: begin
                    direction_ff <= ioxp_pkg::ioxp_put(direction_ff, bank, byte_in);
                end
                ioxp_pkg::GRP_SUPPRESS: begin
                    suppress_ff <= ioxp_pkg::ioxp_put(suppress_ff, bank, byte_in);
                end
                default: begin
                    level_out_ff <= level_out_ff;
                end
            endcase
        end
    end

    // Tells the reference side that direction or suppress changed
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            cfg_tog_ff <= 1'b0;
        end else if (wr_now && ((grp == ioxp_pkg::GRP_DIRECTION)
                                || (grp == ioxp_pkg::GRP_SUPPRESS))) begin
            cfg_tog_ff <= ~cfg_tog_ff;
        end
    end

    // Read byte shifts out MSB first on falling edges
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            rbyte_ff <= 8'h00;
        end else if (load_rd) begin
            rbyte_ff <= rd_byte;
        end else if (state_ff == LS_RDAT) begin
            rbyte_ff <= {rbyte_ff[6:0], 1'b0};
        end
    end

    // Reading an input bank re-arms its interrupt on the reference side
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            rd_tog_ff <= 1'b0;
            rd_bank_ff <= 3'h0;
        end else if (load_rd && bank_ok && (grp == ioxp_pkg::GRP_LEVEL_IN)) begin
            rd_tog_ff <= ~rd_tog_ff;
            rd_bank_ff <= bank;
        end
    end

    // Input snapshot arrives by request/acknowledge toggles
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            in_lnk_ff <= 40'h00_0000_0000;
            snap_ack_ff <= 1'b0;
        end else if (snap_req_s != snap_ack_ff) begin
            in_lnk_ff <= snap_ff;
            snap_ack_ff <= snap_req_s;
        end
    end

    always_comb begin
        case (state_ff)
            LS_AACK: lnk.drive_low = addr_match;
            LS_CACK: lnk.drive_low = 1'b1;
            LS_WACK: lnk.drive_low = ack_ok_ff;
            LS_RDAT: lnk.drive_low = ~rbyte_ff[7];
            default: lnk.drive_low = 1'b0;
        endcase
    end

    // Reference clock domain
    logic [40:0] pin_s;
    logic [39:0] pin_lvl;
    logic oe_n_s;
    logic [2:0] ref_s;
    logic cfg_seen_ff;
    logic rd_seen_ff;
    logic [2:0] armed_ff;
    logic [39:0] dir_r_ff;
    logic [39:0] sup_r_ff;
    logic [39:0] base_ff;
    logic irq_ff;
    logic [39:0] watch;
    logic nxt_irq;

    ioxp_sync #(.W(41)) u_pin_sync (
        .clk(ref_clk),
        .rst(rst),
        .d({oe_n, pins_bank4_in, pins_bank3_in, pins_bank2_in, pins_bank1_in, pins_bank0_in}),
        .q(pin_s)
    );
    assign pin_lvl = pin_s[39:0];
    assign oe_n_s = pin_s[40];

    ioxp_sync #(.W(3)) u_tog_sync (
        .clk(ref_clk),
        .rst(rst),
        .d({snap_ack_ff, rd_tog_ff, cfg_tog_ff}),
        .q(ref_s)
    );

    // Snapshot is held still until the serial side has taken it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            snap_ff <= 40'h00_0000_0000;
            snap_req_ff <= 1'b0;
        end else if (snap_req_ff == ref_s[2]) begin
            snap_ff <= pin_lvl;
            snap_req_ff <= ~snap_req_ff;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_seen_ff <= 1'b0;
            dir_r_ff <= ioxp_pkg::DIRECTION_RST;
            sup_r_ff <= ioxp_pkg::SUPPRESS_RST;
        end else if (ref_s[0] != cfg_seen_ff) begin
            cfg_seen_ff <= ref_s[0];
            dir_r_ff <= direction_ff;
            sup_r_ff <= suppress_ff;
        end
    end

    // Reference levels: retaken until the synchroniser holds real pins, then per read bank
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armed_ff <= 3'h0;
            rd_seen_ff <= 1'b0;
            base_ff <= 40'h00_0000_0000;
        end else begin
            armed_ff <= {armed_ff[1:0], 1'b1};
            rd_seen_ff <= ref_s[1];
            if (!armed_ff[2]) begin
                base_ff <= pin_lvl;
            end else begin
                base_ff <= (base_ff & dir_r_ff) | (pin_lvl & ~dir_r_ff);
                if (ref_s[1] != rd_seen_ff) begin
                    base_ff[{rd_bank_ff, 3'b000} +: 8] <= pin_lvl[{rd_bank_ff, 3'b000} +: 8];
                end
            end
        end
    end

    assign watch = (pin_lvl ^ base_ff) & dir_r_ff & ~sup_r_ff;
    assign nxt_irq = armed_ff[2] && (|watch);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign irq_n_out = 1'b0;
    assign irq_n_oe = irq_ff;

    // Output enable high floats every output; outside may PWM it
    assign pins_bank0_out = ioxp_pkg::ioxp_get(level_out_ff, 3'h0);
    assign pins_bank1_out = ioxp_pkg::ioxp_get(level_out_ff, 3'h1);
    assign pins_bank2_out = ioxp_pkg::ioxp_get(level_out_ff, 3'h2);
    assign pins_bank3_out = ioxp_pkg::ioxp_get(level_out_ff, 3'h3);
    assign pins_bank4_out = ioxp_pkg::ioxp_get(level_out_ff, 3'h4);
    assign pins_bank0_oe = ioxp_pkg::ioxp_get(~direction_ff, 3'h0) & {8{~oe_n_s}};
    assign pins_bank1_oe = ioxp_pkg::ioxp_get(~direction_ff, 3'h1) & {8{~oe_n_s}};
    assign pins_bank2_oe = ioxp_pkg::ioxp_get(~direction_ff, 3'h2) & {8{~oe_n_s}};
    assign pins_bank3_oe = ioxp_pkg::ioxp_get(~direction_ff, 3'h3) & {8{~oe_n_s}};
    assign pins_bank4_oe = ioxp_pkg::ioxp_get(~direction_ff, 3'h4) & {8{~oe_n_s}};
endmodule : ioxp_top

// ==== ioxp_pkg.sv ====
/*
 * Shared constants and helpers for the forty-pin serial I/O expander:
 * bank geometry, command byte layout, register groups and reset values.
 * Assumes nothing of its surroundings; every user names items package::name.
 */
package ioxp_pkg;
    localparam int NUM_BANKS = 5;
    localparam int BANK_W = 8;
    localparam int PIN_W = 40;

    // Upper four bits of the seven-bit target address; low three come from pins
    localparam logic [3:0] TGT_ADDR_HI = 4'h2;

    // Command byte: bit 7 auto-increment, bits 5:3 register group, bits 2:0 bank
    localparam logic [7:0] CMD_RST = 8'h80;
    localparam int CMD_AUTOINC_BIT = 7;
    localparam logic [2:0] LAST_BANK = 3'h4;

    localparam logic [2:0] GRP_LEVEL_IN = 3'h0;
    localparam logic [2:0] GRP_LEVEL_OUT = 3'h1;
    localparam logic [2:0] GRP_INVERT = 3'h2;
    localparam logic [2:0] GRP_DIRECTION = 3'h3;
    localparam logic [2:0] GRP_SUPPRESS = 3'h4;

    // Direction bit set means input
    localparam logic [39:0] LEVEL_OUT_RST = 40'h00_0000_0000;
    localparam logic [39:0] INVERT_RST = 40'h00_0000_0000;
    localparam logic [39:0] DIRECTION_RST = 40'hff_ffff_ffff;
    localparam logic [39:0] SUPPRESS_RST = 40'h00_0000_0000;

    function automatic logic [7:0] ioxp_get(input logic [39:0] v, input logic [2:0] b);
        return v[{b, 3'b000} +: 8];
    endfunction : ioxp_get

    function automatic logic [39:0] ioxp_put(input logic [39:0] v, input logic [2:0] b,
                                             input logic [7:0] d);
        logic [39:0] r;
        r = v;
        r[{b, 3'b000} +: 8] = d;
        return r;
    endfunction : ioxp_put

    // Reserved banks 5..7 are skipped: bank 4 wraps to bank 0
    function automatic logic [2:0] ioxp_bank_next(input logic [2:0] b);
        return (b >= LAST_BANK) ? 3'h0 : 3'(b + 3'h1);
    endfunction : ioxp_bank_next
endpackage : ioxp_pkg

// ==== ioxp_link_if.sv ====
/*
 * Carrier between the serial line edge detector and the expander core.
 * Assumes the detector and the core share the serial clock line.
 */
`timescale 1ns/1ps
interface ioxp_link_if;
    logic start_ff;
    logic stop_ff;
    logic drive_low;

    modport det (output start_ff, output stop_ff, input drive_low);
    modport core (input start_ff, input stop_ff, output drive_low);
endinterface : ioxp_link_if

// ==== ioxp_sync.sv ====
/*
 * Two-stage synchroniser for a vector of levels.
 * Assumes each bit is an independent level or a slow toggle.
 */
`timescale 1ns/1ps
module ioxp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule : ioxp_sync

// ==== ioxp_edge.sv ====
/*
 * Start and stop detection on the serial lines, plus the data line driver.
 * Start and stop are toggles so the core, clocked by the serial clock,
 * sees them on its next rising edge. The driver changes only on falling
 * serial clock, so the data line is stable while the clock is high.
 */
`timescale 1ns/1ps
module ioxp_edge (
    // Serial lines
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Reset
    input wire logic rst,
    // Core side
    ioxp_link_if.det lnk
);
    logic sda_drive_ff;

    // Data falling while clock high: start
    always_ff @(negedge sda_in or posedge rst) begin
        if (rst) begin
            lnk.start_ff <= 1'b0;
        end else if (scl) begin
            lnk.start_ff <= ~lnk.start_ff;
        end
    end

    // Data rising while clock high: stop
    always_ff @(posedge sda_in or posedge rst) begin
        if (rst) begin
            lnk.stop_ff <= 1'b0;
        end else if (scl) begin
            lnk.stop_ff <= ~lnk.stop_ff;
        end
    end

    always_ff @(negedge scl or posedge rst) begin
        if (rst) begin
            sda_drive_ff <= 1'b0;
        end else begin
            sda_drive_ff <= lnk.drive_low;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_drive_ff;
endmodule : ioxp_edge

// ==== ioxp_chk.sv ====
/* Port checker for the expander top.
 * Bound from the bench top file; sees top ports only. */
`timescale 1ns/1ps
module ioxp_chk (
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl,
    // Serial and control
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic oe_n,
    // Pins
    input wire logic [7:0] pins_bank0_in,
    input wire logic [7:0] pins_bank1_in,
    input wire logic [7:0] pins_bank2_in,
    input wire logic [7:0] pins_bank3_in,
    input wire logic [7:0] pins_bank4_in,
    input wire logic [7:0] pins_bank0_out,
    input wire logic [7:0] pins_bank0_oe,
    input wire logic [7:0] pins_bank1_oe,
    input wire logic [7:0] pins_bank2_oe,
    input wire logic [7:0] pins_bank3_oe,
    input wire logic [7:0] pins_bank4_oe,
    // Interrupt
    input wire logic irq_n_out,
    input wire logic irq_n_oe
);
    logic [39:0] ins, oes, ins_ff;
    logic [3:0] age_ff;
    assign ins = {pins_bank4_in, pins_bank3_in, pins_bank2_in, pins_bank1_in, pins_bank0_in};
    assign oes = {pins_bank4_oe, pins_bank3_oe, pins_bank2_oe, pins_bank1_oe, pins_bank0_oe};
    // Edges since any pin moved, saturating
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ins_ff <= 40'h0;
            age_ff <= 4'hf;
        end else begin
            ins_ff <= ins;
            age_ff <= (ins != ins_ff) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
        end
    end
    sequence s_oe_hi; oe_n [*4]; endsequence
    property p_rst_in; @(posedge ref_clk) disable iff (rst) $fell(rst) |-> oes == 40'h0; endproperty
    a_rst_in: assert property (p_rst_in) else $error("pins driven after reset");
    property p_oe_off; @(posedge ref_clk) disable iff (rst) s_oe_hi |-> oes == 40'h0; endproperty
    a_oe_off: assert property (p_oe_off) else $error("pins driven while disabled");
    property p_oe_src;
        @(posedge ref_clk) disable iff (rst) oes != 40'h0 |-> !$past(oe_n, 2) || !$past(oe_n, 3);
    endproperty
    a_oe_src: assert property (p_oe_src) else $error("pins driven without enable");
    property p_irq_od; @(posedge ref_clk) disable iff (rst) irq_n_out == 1'b0; endproperty
    a_irq_od: assert property (p_irq_od) else $error("interrupt line driven high");
    property p_sda_od; @(posedge scl) disable iff (rst) sda_out == 1'b0; endproperty
    a_sda_od: assert property (p_sda_od) else $error("data line driven high");
    property p_out_ack; @(posedge scl) disable iff (rst) !$stable(pins_bank0_out) |-> sda_oe; endproperty
    a_out_ack: assert property (p_out_ack) else $error("output moved off acknowledge");
    property p_irq_src; @(posedge ref_clk) disable iff (rst) $rose(irq_n_oe) |-> age_ff <= 4'h6; endproperty
    a_irq_src: assert property (p_irq_src) else $error("interrupt without pin change");
    property p_irq_rst; @(posedge ref_clk) disable iff (rst) $fell(rst) |-> !irq_n_oe [*2]; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("interrupt right after reset");
endmodule : ioxp_chk

// ==== ioxp_host.sv ====
/* Serial bus controller model for the expander link.
 * Data line is pulled up; the device pulls it low with sda_oe. */
`timescale 1ns/1ps
module ioxp_host (
    // Serial lines
    output logic scl,
    output logic sda,
    // Device pull-down
    input wire logic sda_oe
);
    logic drv = 1'b1;
    assign sda = drv & ~sda_oe;
    // Clock stands high between frames
    initial scl = 1'b1;
    task automatic st();
        #80 drv = 1'b0;
        #80 scl = 1'b0;
    endtask : st
    task automatic sp();
        #40 drv = 1'b0;
        #40 scl = 1'b1;
        #80 drv = 1'b1;
        #80;
    endtask : sp
    // Bit 0 of d is our own acknowledge, 1 releases the line
    task automatic xb(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            #40 drv = d[i];
            #40 scl = 1'b1;
            #40 r[i] = sda;
            #40 scl = 1'b0;
        end
    endtask : xb
endmodule : ioxp_host

// ==== ioxp_tb_top.sv ====
/* Self-checking bench for the expander top.
 * Assumes the controller model and the checker are compiled first. */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", nm, e, s); end end
module ioxp_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda, sda_oe, oe_n, irq_oe;
    logic [2:0] asel;
    logic [6:0] adr;
    logic [39:0] pin_in, pout, poe, v;
    logic [31:0] seed = 32'h0001_3d06;
    int mdl [5][5];
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    ioxp_top u_dut (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .addr_sel0(asel[0]), .addr_sel1(asel[1]), .addr_sel2(asel[2]),
        .oe_n(oe_n), .irq_n_out(), .irq_n_oe(irq_oe),
        .pins_bank0_in(pin_in[7:0]), .pins_bank0_out(pout[7:0]), .pins_bank0_oe(poe[7:0]),
        .pins_bank1_in(pin_in[15:8]), .pins_bank1_out(pout[15:8]), .pins_bank1_oe(poe[15:8]),
        .pins_bank2_in(pin_in[23:16]), .pins_bank2_out(pout[23:16]), .pins_bank2_oe(poe[23:16]),
        .pins_bank3_in(pin_in[31:24]), .pins_bank3_out(pout[31:24]), .pins_bank3_oe(poe[31:24]),
        .pins_bank4_in(pin_in[39:32]), .pins_bank4_out(pout[39:32]), .pins_bank4_oe(poe[39:32]));
    ioxp_host u_host (.scl(scl), .sda(sda), .sda_oe(sda_oe));
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    function automatic logic [39:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {seed[7:0], seed};
    endfunction : rnd
    function automatic logic [39:0] grp(input int g);
        for (int b = 0; b < 5; b++) grp[8*b+:8] = 8'(mdl[g][b]);
    endfunction : grp
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tk
    task automatic xw(input logic [7:0] d, input logic nk);
        logic [8:0] r;
        u_host.xb({d, 1'b1}, r);
        `CHK("ack", nk, r[0])
    endtask : xw
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input int n);
        int b;
        b = c[2:0];
        u_host.st();
        xw({a, 1'b0}, a != adr);
        if (a == adr) begin
            xw(c, 1'b0);
            for (int i = 0; i < n; i++) begin
                xw(v[8*i+:8], c[5:3] == 3'h0);
                mdl[c[5:3]][b] = v[8*i+:8];
                if (c[7]) b = (b + 1) % 5;
            end
        end
        u_host.sp();
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic setp);
        logic [8:0] r;
        logic [7:0] e;
        int b;
        b = c[2:0];
        if (setp) wr(adr, c, 0);
        u_host.st();
        xw({adr, 1'b1}, 1'b0);
        for (int i = 0; i < 5; i++) begin
            e = (c[5:3] == 3'h0) ? pin_in[8*b+:8] ^ 8'(mdl[2][b]) : 8'(mdl[c[5:3]][b]);
            u_host.xb({8'hff, i == 4}, r);
            `CHK("rd", e, r[8:1])
            b = (b + 1) % 5;
        end
        u_host.sp();
    endtask : rd
    task automatic chk_pins();
        tk(6);
        for (int b = 0; b < 5; b++) begin
            `CHK("out", 8'(mdl[1][b]), pout[8*b+:8])
            `CHK("oe", ~8'(mdl[3][b]) & {8{~oe_n}}, poe[8*b+:8])
        end
    endtask : chk_pins
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    initial begin
        oe_n = 1'b0;
        v = rnd();
        asel = v[2:0];
        adr = {ioxp_pkg::TGT_ADDR_HI, asel};
        pin_in = rnd();
        for (int g = 0; g < 5; g++)
            for (int b = 0; b < 5; b++) mdl[g][b] = (g == 3) ? 255 : 0;
        tk(12);
        rst = 1'b0;
        chk_pins();
        rd(8'h80, 1'b0);
        for (int g = 1; g < 5; g++) begin
            v = rnd();
            wr(adr, {2'b10, 3'(g), 3'h0}, 5);
        end
        chk_pins();
        for (int g = 0; g < 5; g++) rd({2'b10, 3'(g), 3'h2}, 1'b1);
        v = rnd();
        wr(adr ^ 7'h01, 8'h88, 5);
        wr(adr, 8'h81, 1);
        wr(adr, 8'h0b, 2);
        chk_pins();
        for (int p = 0; p < 4; p++) begin
            tk(1);
            oe_n = ~oe_n;
            chk_pins();
        end
        for (int m = 0; m < 2; m++) begin
            v = m ? 40'h0 : '1;
            wr(adr, 8'ha0, 5);
            v = rnd();
            tk(1);
            pin_in ^= v;
            tk(8);
            `CHK("irq", |(v & grp(3) & ~grp(4)), irq_oe)
            pin_in ^= v;
            tk(8);
            `CHK("irq", 1'b0, irq_oe)
        end
        pin_in ^= v;
        tk(8);
        `CHK("irq", |(v & grp(3)), irq_oe)
        rd(8'h80, 1'b1);
        tk(8);
        `CHK("irq", 1'b0, irq_oe)
        test_done();
    end
endmodule : ioxp_tb_top
bind ioxp_top ioxp_chk u_chk (.ref_clk, .rst, .scl, .sda_out, .sda_oe, .oe_n, .pins_bank0_in,
    .pins_bank1_in, .pins_bank2_in, .pins_bank3_in, .pins_bank4_in, .pins_bank0_out,
    .pins_bank0_oe, .pins_bank1_oe, .pins_bank2_oe, .pins_bank3_oe, .pins_bank4_oe,
    .irq_n_out, .irq_n_oe);
